/* core/srt_defs.vh */
// constants for the split auto-reload timer
`ifndef SRT_DEFS_VH
`define SRT_DEFS_VH

// register word indices; byte address is four times the index
`define SRT_IDX_CTRL    10'h091
`define SRT_IDX_RLD_LO  10'h092
`define SRT_IDX_RLD_HI  10'h093
`define SRT_IDX_CNT_LO  10'h094
`define SRT_IDX_CNT_HI  10'h095
`define SRT_IDX_CLKCTL  10'h098
`define SRT_IDX_IRQEN   10'h099

// control register fields
`define SRT_B_HFLAG     7
`define SRT_B_LFLAG     6
`define SRT_B_LIE       5
`define SRT_B_SPLIT     3
`define SRT_B_RUN       2
`define SRT_B_XCLK      0

// clock control register fields
`define SRT_B_LO_SEL    0
`define SRT_B_HI_SEL    1
`define SRT_B_CAPT      4

// extended interrupt enable field
`define SRT_B_TIE       7

// reset and limit values
`define SRT_BYTE_ZERO   8'h00
`define SRT_BYTE_ONES   8'hff
`define SRT_WORD_ZERO   32'h0000_0000
`define SRT_DIV12_LAST  4'hb
`define SRT_DIV8_LAST   3'h7
`define SRT_DIV_ZERO    4'h0
`define SRT_DIV8_ZERO   3'h0

`endif

/* core/srt_timer.v */
// split auto-reload timer with apb register access
`timescale 1ns/1ps
`include "srt_defs.vh"

module srt_timer #(
    parameter ADDR_W = 12
) (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata_r,
    output reg               pready_r,
    output reg               pslverr_r,
    input  wire              ext_osc_in,
    output reg               timer_irq_r
);

    // timer and configuration state
    reg [7:0] cnt_lo_r;
    reg [7:0] cnt_hi_r;
    reg [7:0] rld_lo_r;
    reg [7:0] rld_hi_r;
    reg       hflag_r;
    reg       lflag_r;
    reg       lie_r;
    reg       split_r;
    reg       run_r;
    reg       xclk_r;
    reg       lo_sel_r;
    reg       hi_sel_r;
    reg       capt_r;
    reg       tie_r;
    reg [3:0] div12_r;
    reg [2:0] div8_r;
    reg       ext_s1_r;
    reg       ext_s2_r;
    reg       ext_s3_r;

    // combinational next state and decode
    reg [7:0] cnt_lo_nxt;
    reg [7:0] cnt_hi_nxt;
    reg       hset;
    reg       lset;
    reg [7:0] rdata;
    reg       hit;

    // apb phase and address decode
    wire       acc     = psel & penable;
    wire       wr_fire = acc & pready_r & pwrite;
    wire [9:0] widx    = paddr[ADDR_W-1:2];
    wire       algn    = (paddr[1:0] == 2'b00);

    // external clock synchroniser, third stage for edge
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_osc_in;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // rising edge of the synchronised external clock
    wire ext_rise = ext_s2_r & ~ext_s3_r;

    // prescalers for div 12 and ext div 8
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div12_r <= `SRT_DIV_ZERO;
            div8_r  <= `SRT_DIV8_ZERO;
        end else begin
            if (div12_r == `SRT_DIV12_LAST)
                div12_r <= `SRT_DIV_ZERO;
            else
                div12_r <= div12_r + 4'h1;
            if (ext_rise)
                div8_r <= div8_r + 3'h1;
        end
    end

    // shared slow tick: div 12 or every eighth external edge
    wire tick12 = (div12_r == `SRT_DIV12_LAST);
    wire tick8  = ext_rise & (div8_r == `SRT_DIV8_LAST);
    wire slow   = xclk_r ? tick8 : tick12;

    // per-byte clock choice: system clock or shared slow tick
    wire [1:0] byte_sel = {hi_sel_r, lo_sel_r};
    wire [1:0] byte_tick;
    genvar     gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_tick
            assign byte_tick[gi] = byte_sel[gi] | slow;
        end
    endgenerate
    wire tick_lo = byte_tick[0];
    wire tick_hi = byte_tick[1];

    // capture enable does not alter split behaviour
    wire split_on = split_r | (split_r & capt_r);

    // wrap detectors for each byte and the whole word
    wire lo_full  = (cnt_lo_r == `SRT_BYTE_ONES);
    wire hi_full  = (cnt_hi_r == `SRT_BYTE_ONES);
    wire all_full = lo_full & hi_full;

    // run gates the word and the split high byte
    wire word_go  = run_r & tick_lo;
    wire hi_go    = run_r & tick_hi;

    always @* begin
        cnt_lo_nxt = cnt_lo_r;
        cnt_hi_nxt = cnt_hi_r;
        hset       = 1'b0;
        lset       = 1'b0;
        if (!split_on) begin
            if (word_go) begin
                if (all_full) begin
                    cnt_lo_nxt = rld_lo_r;
                    cnt_hi_nxt = rld_hi_r;
                    hset       = 1'b1;
                    // a word wrap is also a low byte wrap
                    lset       = 1'b1;
                end else if (lo_full) begin
                    cnt_lo_nxt = `SRT_BYTE_ZERO;
                    cnt_hi_nxt = cnt_hi_r + 8'h01;
                    lset       = 1'b1;
                end else begin
                    cnt_lo_nxt = cnt_lo_r + 8'h01;
                end
            end
        end else begin
            // low byte free-running in split mode
            if (tick_lo) begin
                if (lo_full) begin
                    cnt_lo_nxt = rld_lo_r;
                    lset       = 1'b1;
                end else begin
                    cnt_lo_nxt = cnt_lo_r + 8'h01;
                end
            end
            if (hi_go) begin
                if (hi_full) begin
                    cnt_hi_nxt = rld_hi_r;
                    hset       = 1'b1;
                end else begin
                    cnt_hi_nxt = cnt_hi_r + 8'h01;
                end
            end
        end
    end

    // register read mux and decode
    always @* begin
        rdata = `SRT_BYTE_ZERO;
        hit   = algn;
        case (widx)
            `SRT_IDX_CTRL: begin
                rdata[`SRT_B_HFLAG] = hflag_r;
                rdata[`SRT_B_LFLAG] = lflag_r;
                rdata[`SRT_B_LIE]   = lie_r;
                rdata[`SRT_B_SPLIT] = split_r;
                rdata[`SRT_B_RUN]   = run_r;
                rdata[`SRT_B_XCLK]  = xclk_r;
            end
            `SRT_IDX_RLD_LO: rdata = rld_lo_r;
            `SRT_IDX_RLD_HI: rdata = rld_hi_r;
            `SRT_IDX_CNT_LO: rdata = cnt_lo_r;
            `SRT_IDX_CNT_HI: rdata = cnt_hi_r;
            `SRT_IDX_CLKCTL: begin
                rdata[`SRT_B_LO_SEL] = lo_sel_r;
                rdata[`SRT_B_HI_SEL] = hi_sel_r;
                rdata[`SRT_B_CAPT]   = capt_r;
            end
            `SRT_IDX_IRQEN: rdata[`SRT_B_TIE] = tie_r;
            default: hit = 1'b0;
        endcase
    end

    // first access cycle; a refused one answers with an error
    wire start_acc = acc & ~pready_r;
    wire refuse    = start_acc & ~hit;
    wire rd_take   = start_acc & ~pwrite;

    // a completing aligned write
    wire wr_ok     = wr_fire & algn;

    // apb answer: ready one cycle into the access phase
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `SRT_WORD_ZERO;
        end else begin
            pready_r  <= start_acc;
            pslverr_r <= refuse;
            if (rd_take) begin
                // refused reads return zero, not an aliased register
                if (hit)
                    prdata_r <= {24'h00_0000, rdata};
                else
                    prdata_r <= `SRT_WORD_ZERO;
            end
        end
    end

    // configuration registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lie_r    <= 1'b0;
            split_r  <= 1'b0;
            run_r    <= 1'b0;
            xclk_r   <= 1'b0;
            lo_sel_r <= 1'b0;
            hi_sel_r <= 1'b0;
            capt_r   <= 1'b0;
            tie_r    <= 1'b0;
            rld_lo_r <= `SRT_BYTE_ZERO;
            rld_hi_r <= `SRT_BYTE_ZERO;
        end else if (wr_ok) begin
            // writes land on the completing edge
            case (widx)
                `SRT_IDX_CTRL: begin
                    lie_r   <= pwdata[`SRT_B_LIE];
                    split_r <= pwdata[`SRT_B_SPLIT];
                    run_r   <= pwdata[`SRT_B_RUN];
                    xclk_r  <= pwdata[`SRT_B_XCLK];
                end
                `SRT_IDX_RLD_LO: rld_lo_r <= pwdata[7:0];
                `SRT_IDX_RLD_HI: rld_hi_r <= pwdata[7:0];
                `SRT_IDX_CLKCTL: begin
                    lo_sel_r <= pwdata[`SRT_B_LO_SEL];
                    hi_sel_r <= pwdata[`SRT_B_HI_SEL];
                    capt_r   <= pwdata[`SRT_B_CAPT];
                end
                `SRT_IDX_IRQEN: tie_r <= pwdata[`SRT_B_TIE];
                default: ;
            endcase
        end
    end

    // write strobes for flag and counter registers
    wire wr_ctrl = wr_ok & (widx == `SRT_IDX_CTRL);
    wire wr_clo  = wr_ok & (widx == `SRT_IDX_CNT_LO);
    wire wr_chi  = wr_ok & (widx == `SRT_IDX_CNT_HI);

    // counters and overflow flags
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_lo_r <= `SRT_BYTE_ZERO;
            cnt_hi_r <= `SRT_BYTE_ZERO;
            hflag_r  <= 1'b0;
            lflag_r  <= 1'b0;
        end else begin
            cnt_lo_r <= wr_clo ? pwdata[7:0] : cnt_lo_nxt;
            cnt_hi_r <= wr_chi ? pwdata[7:0] : cnt_hi_nxt;
            // only software clears; set beats clear
            hflag_r <= (wr_ctrl ? pwdata[`SRT_B_HFLAG] : hflag_r) | hset;
            lflag_r <= (wr_ctrl ? pwdata[`SRT_B_LFLAG] : lflag_r) | lset;
        end
    end

    wire irq_hi = tie_r & hflag_r;
    // low overflow requests only with its own enable
    wire irq_lo = tie_r & lflag_r & lie_r;

    // shared interrupt request level, falls with the flags
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            timer_irq_r <= 1'b0;
        else
            timer_irq_r <= irq_hi | irq_lo;
    end

endmodule // srt_timer

/* sim/srt_timer_assertions.sv */
// assertions on the timer's bus and interrupt ports
`timescale 1ns/1ps
module srt_timer_assertions #(
    parameter ADDR_W = 12
) (
    input wire              ref_clk,
    input wire              rst,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata_r,
    input wire              pready_r,
    input wire              pslverr_r,
    input wire              ext_osc_in,
    input wire              timer_irq_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // access cycle, then a one-cycle ready
    sequence s_wait;
        psel && penable && !pready_r;
    endsequence
    sequence s_done;
        pready_r ##1 !pready_r;
    endsequence
    // read completion qualifier
    wire rd = pready_r && !pwrite;
    a_wait_one: assert property (s_wait |=> s_done)
        else $error("ready not after one wait");
    a_ready_access: assert property (pready_r |-> psel && penable)
        else $error("ready outside access");
    a_err_ready: assert property (pslverr_r |-> pready_r)
        else $error("error without ready");
    a_upper_zero: assert property (rd |-> prdata_r[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_ctrl_unused: assert property (rd && paddr == 12'h244 |-> !prdata_r[4] && !prdata_r[1])
        else $error("unused control bit set");
    a_unaligned_err: assert property (pready_r && paddr[1:0] != 2'h0 |-> pslverr_r)
        else $error("unaligned access accepted");
    a_err_rdata: assert property (rd && pslverr_r |-> prdata_r == 32'h0000_0000)
        else $error("error read not zero");
    a_irq_off: assert property (pready_r && pwrite && paddr == 12'h264 && !pwdata[7] |=> ##1 !timer_irq_r)
        else $error("irq stays with enable off");
endmodule // srt_timer_assertions
bind srt_timer srt_timer_assertions #(.ADDR_W(ADDR_W)) i_chk (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .ext_osc_in(ext_osc_in), .timer_irq_r(timer_irq_r));

/* sim/tb_srt_timer.sv */
// self-checking bench for the split auto-reload timer
`timescale 1ns/1ps
`include "srt_defs.vh"
module tb_srt_timer;
    reg         ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ext_osc_in = 0, e;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, q;
    wire [31:0] prdata_r;
    wire        pready_r, pslverr_r, timer_irq_r;
    int         errors = 0, total_checks = 0, cyc = 0;
    int         lo, hi, rl, rh, hf, lf, ie, sp, run, tie, n, k, tc, t1;
    srt_timer i_srt_timer (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
        .pready_r(pready_r), .pslverr_r(pslverr_r), .ext_osc_in(ext_osc_in),
        .timer_irq_r(timer_irq_r));
    // 125 mhz clock
    always #4 ref_clk = ~ref_clk;
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            results();
        end
    end
    task results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        total_checks++;
        if (got !== ex) begin
            errors++;
            $display("ERROR %s exp %h got %h", nm, ex, got);
        end
    endtask
    function [11:0] ad(input [9:0] i);
        ad = {i, 2'b00};
    endfunction
    // one apb transfer, held until ready
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready_r !== 1'b1) @(posedge ref_clk);
        q = prdata_r;
        e = pslverr_r;
        tc = cyc;
        psel <= 0;
        penable <= 0;
    endtask
    // eight external edges per tick, then sync settle
    task pulse(input int t);
        repeat (t * 8) begin
            @(posedge ref_clk) ext_osc_in <= 1;
            repeat (2) @(posedge ref_clk);
            ext_osc_in <= 0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
    endtask
    // reference model, one qualified tick
    task step();
        if (sp || run) begin
            lo = (lo + 1) % 256;
            if (lo == 0)
                lf = 1;
            if (sp && lo == 0)
                lo = rl;
            if (sp ? run : lo == 0)
                hi = (hi + 1) % 256;
            if ((sp ? run : lo == 0) && hi == 0) begin
                hi = rh;
                hf = 1;
                if (!sp)
                    lo = rl;
            end
        end
    endtask
    // main sequence
    initial begin
        k = $urandom(32'h7f38);
        repeat (20) @(posedge ref_clk);
        rst <= 0;
        for (k = 0; k < 9; k++) begin
            apb(0, ad(10'h091 + k), 32'h0000_0000);
            chk("reset value", 0, q);
            chk("slverr", k == 5 || k == 6, e);
        end
        apb(1, 12'h245, 32'h0000_00ff);
        chk("unaligned", 1, e);
        apb(1, ad(`SRT_IDX_CTRL), 32'h0000_00ff);
        apb(0, ad(`SRT_IDX_CTRL), 32'h0000_0000);
        chk("ctrl mask", 32'h0000_00ed, q);
        chk("irq masked", 0, timer_irq_r);
        apb(1, ad(`SRT_IDX_CTRL), 32'h0000_0000);
        for (n = 0; n < 10; n++) begin
            sp = $urandom % 2;
            ie = $urandom % 2;
            tie = $urandom % 2;
            run = ($urandom % 4) != 0;
            rl = $urandom % 256;
            rh = $urandom % 256;
            lo = 240 + $urandom % 16;
            hi = 255 - $urandom % 2;
            hf = 0;
            lf = 0;
            apb(1, ad(`SRT_IDX_IRQEN), tie * 128);
            apb(1, ad(`SRT_IDX_RLD_LO), rl);
            apb(1, ad(`SRT_IDX_RLD_HI), rh);
            apb(1, ad(`SRT_IDX_CNT_LO), lo);
            apb(1, ad(`SRT_IDX_CNT_HI), hi);
            apb(1, ad(`SRT_IDX_CTRL), ie * 32 + sp * 8 + run * 4 + 1);
            k = 1 + $urandom % 40;
            pulse(k);
            repeat (k) step();
            apb(0, ad(`SRT_IDX_CNT_LO), 32'h0000_0000);
            chk("count low", lo, q);
            apb(0, ad(`SRT_IDX_CNT_HI), 32'h0000_0000);
            chk("count high", hi, q);
            apb(0, ad(`SRT_IDX_CTRL), 32'h0000_0000);
            chk("flags", hf * 128 + lf * 64 + ie * 32 + sp * 8 + run * 4 + 1, q);
            chk("irq", tie & (hf | lf & ie), timer_irq_r);
            apb(1, ad(`SRT_IDX_CTRL), ie * 32 + sp * 8 + run * 4 + 1);
            repeat (3) @(posedge ref_clk);
            chk("irq cleared", 0, timer_irq_r);
        end
        // split low byte on system clock, capture set, run low
        ie = 0;
        tie = 1;
        sp = 1;
        run = 0;
        hf = 0;
        lf = 0;
        rl = $urandom % 256;
        lo = $urandom % 256;
        hi = $urandom % 256;
        apb(1, ad(`SRT_IDX_IRQEN), 32'h0000_0080);
        apb(1, ad(`SRT_IDX_CTRL), 32'h0000_0009);
        apb(1, ad(`SRT_IDX_RLD_LO), rl);
        apb(1, ad(`SRT_IDX_CNT_LO), lo);
        apb(1, ad(`SRT_IDX_CNT_HI), hi);
        apb(1, ad(`SRT_IDX_CLKCTL), 32'h0000_0013);
        t1 = tc;
        repeat ($urandom % 300) @(posedge ref_clk);
        apb(1, ad(`SRT_IDX_CLKCTL), 32'h0000_0000);
        repeat (tc - t1) step();
        apb(0, ad(`SRT_IDX_CNT_LO), 32'h0000_0000);
        chk("system_clock low", lo, q);
        apb(0, ad(`SRT_IDX_CNT_HI), 32'h0000_0000);
        chk("held high", hi, q);
        apb(0, ad(`SRT_IDX_CTRL), 32'h0000_0000);
        chk("split flags", lf * 64 + 9, q);
        chk("low irq gated", tie & (hf | lf & ie), timer_irq_r);
        // sixteen-bit count on system clock over twelve
        apb(1, ad(`SRT_IDX_CNT_LO), 32'h0000_0000);
        apb(1, ad(`SRT_IDX_CTRL), 32'h0000_0004);
        t1 = tc;
        repeat (24 + $urandom % 200) @(posedge ref_clk);
        apb(1, ad(`SRT_IDX_CTRL), 32'h0000_0000);
        n = tc - t1;
        apb(0, ad(`SRT_IDX_CNT_LO), 32'h0000_0000);
        chk("div12 ticks", 1, q >= n / 12 && q <= (n + 11) / 12);
        results();
    end
endmodule // tb_srt_timer
